/* rtl/rws_pkg.sv */
package rws_pkg;

   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam logic [7:0] ADDR_ENABLE_INDEX  = 8'h6c;
   localparam logic [7:0] ADDR_RUN_CONTROL   = 8'h6f;
   localparam logic [7:0] ADDR_PROGRESS_STAT = 8'h70;

   localparam int BIT_CLOCK_ENABLE    = 8;
   localparam int FLD_WRITE_INDEX_MSB = 4;
   localparam int BIT_CANCEL          = 9;
   localparam int BIT_GO              = 8;
   localparam int FLD_FIRST_INDEX_MSB = 5;
   localparam int FLD_PROGRESS_LSB    = 4;
   localparam int FLD_PROGRESS_MSB    = 9;
   localparam int BIT_RUNNING         = 0;

   localparam logic       RST_CLOCK_ENABLE = 1'b0;
   localparam logic [4:0] RST_WRITE_INDEX  = 5'h00;
   localparam logic       RST_GO           = 1'b0;
   localparam logic [5:0] RST_FIRST_INDEX  = 6'h00;
   localparam logic [5:0] RST_PROGRESS     = 6'h00;

   // ----------------------------------------
   // Index regions
   // ----------------------------------------
   localparam logic [5:0] IDX_RAM_LAST = 6'h1f;
   localparam logic [5:0] IDX_ROM_LAST = 6'h30;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int  CLK_FREQ_HZ     = 40_000_000;
   localparam real STEP_UNIT_US    = 62.5;
   localparam int  STEP_UNIT_CYC   = int'(STEP_UNIT_US * real'(CLK_FREQ_HZ) / 1.0e6);
   localparam int  STEP_BASE_UNITS = 8;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic       last;       // step_last_flag
      logic [3:0] wait_code;  // step_wait_code
      logic [2:0] width;      // step_field_width, code 0..7 = 1..8 bits
      logic [3:0] start;
      logic [7:0] addr;
      logic [7:0] data;
   } rws_step_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] data;
      logic [15:0] mask;
   } rws_ctl_wr_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC  = 2'b10,
      ST_WAIT  = 2'b11
   } rws_state_t;

endpackage

/* rtl/rws_tick_div.sv */
module rws_tick_div #(
   parameter int DIV = 2500
) (
   input  wire logic i_clk,   // System clock
   input  wire logic i_rst,   // Async reset, high
   input  wire logic i_run,   // Counting allowed
   output logic      o_tick   // One-cycle enable
);
   localparam int W = $clog2(DIV);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         tick_next;

   always_comb begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (!i_run) begin
         cnt_next = '0;
      end else if (cnt_reg == W'(DIV - 1)) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= '0;
         o_tick  <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         o_tick  <= tick_next;
      end
   end
endmodule // rws_tick_div

/* rtl/rws_seq_run_ctrl.sv */
// Notes on behaviour
// [R1] Sequencer runs only while its clock enable bit is set; reset value 0.
// [R2] Host enables the system clock before using the sequencer.
// [R3] Write first-step index, then go bit; sequence starts at that index.
// [R4] Consecutive steps execute until a step with its last flag set.
// [R5] Go bit clears itself when the sequence finishes.
// [R6] Index 0-31 RAM, 32-48 ROM, 49-63 reserved.
// [R7] Writing cancel stops the sequence at once, control returns to host.
// [R8] Running flag at status bit 0 reads 1 while a sequence executes.
// [R9] Host avoids ordinary control register access while running.
// [R10] Sequencer registers stay accessible while running.
// [R11] Status bits 9:4 show the index of the most recently accessed step.
// [R12] After completion the progress index holds the final step index.
// [R13] Completion sets the done interrupt flag.
// [R14] Done flag raised only together with the not-running state.
// [R15] Step last flag stops the sequencer after that step.
// [R16] Step time is 62.5 us times (2^wait code + 8).
// [R17] Width code 0..7 means 1..8 data bits.
// [R18] Host keeps the master clock present while the sequencer is used.
// [R19] Cancel clears both running flag and go bit.
module rws_seq_run_ctrl
   import rws_pkg::*;
#(
   parameter int UNIT_CYC = STEP_UNIT_CYC
) (
   input  wire logic               i_clk,                 // System clock, 40 MHz
   input  wire logic               i_rst,                 // Async reset, high
   input  wire logic               i_system_clock_enable, // System clock enabled
   input  wire logic               i_reg_wr,              // Register write strobe
   input  wire logic               i_reg_rd,              // Register read strobe
   input  wire logic [7:0]         i_reg_addr,            // Register address
   input  wire logic [15:0]        i_reg_wdata,           // Register write data
   output logic [15:0]             o_reg_rdata,           // Register read data
   output logic                    o_ctl_blocked,         // Other registers refused
   output logic                    o_step_rd,             // Step memory read
   output logic [5:0]              o_step_index,          // Step memory index
   input  wire rws_pkg::rws_step_t i_step_word,           // Step, sampled in the read cycle
   output logic                    o_ctl_wr,              // Control register write
   output rws_pkg::rws_ctl_wr_t    o_ctl,                 // Address, data, mask
   output logic                    o_seq_done_irq_flag,   // Completion event pulse
   output logic [4:0]              o_seq_write_index      // Programming index
);
   import rws_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   rws_state_t  state_reg, state_next;
   logic        clk_en_reg, clk_en_next;
   logic [4:0]  wr_idx_reg, wr_idx_next;
   logic        go_reg, go_next;
   logic [5:0]  first_idx_reg, first_idx_next;
   logic [5:0]  progress_reg, progress_next;
   logic        busy_reg, busy_next;
   logic [5:0]  step_idx_reg, step_idx_next;
   rws_step_t   step_reg, step_next;
   logic [15:0] wait_reg, wait_next;
   logic        done_reg, done_next;
   logic        ctl_wr_reg, ctl_wr_next;
   rws_ctl_wr_t ctl_reg, ctl_next;
   logic        step_rd_reg, step_rd_next;
   logic [15:0] rdata_reg, rdata_next;

   logic        run_ok;
   logic        tick;
   logic        wr_en_idx, wr_run, cancel;
   logic [7:0]  low_mask;

   // [R1] sequencer clock gate
   // [R18] depends on system clock running
   assign run_ok = clk_en_reg & i_system_clock_enable;

   rws_tick_div #(
      .DIV (UNIT_CYC)
   ) u_tick (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_run  (run_ok && state_reg == ST_WAIT),
      .o_tick (tick)
   );

   assign wr_en_idx = i_reg_wr && i_reg_addr == ADDR_ENABLE_INDEX;
   assign wr_run    = i_reg_wr && i_reg_addr == ADDR_RUN_CONTROL;
   assign cancel    = wr_run && i_reg_wdata[BIT_CANCEL];

   // [R17] width code plus one bits
   assign low_mask = 8'hff >> (3'h7 - step_reg.width);

   // ----------------------------------------
   // Register file and sequencer
   // ----------------------------------------
   always_comb begin
      state_next     = state_reg;
      clk_en_next    = clk_en_reg;
      wr_idx_next    = wr_idx_reg;
      go_next        = go_reg;
      first_idx_next = first_idx_reg;
      progress_next  = progress_reg;
      busy_next      = busy_reg;
      step_idx_next  = step_idx_reg;
      step_next      = step_reg;
      wait_next      = wait_reg;
      done_next      = 1'b0;
      ctl_wr_next    = 1'b0;
      ctl_next       = ctl_reg;
      step_rd_next   = 1'b0;
      rdata_next     = rdata_reg;

      // [R10] own registers open while running
      if (wr_en_idx) begin
         clk_en_next = i_reg_wdata[BIT_CLOCK_ENABLE];
         wr_idx_next = i_reg_wdata[FLD_WRITE_INDEX_MSB:0];
      end
      if (wr_run) begin
         first_idx_next = i_reg_wdata[FLD_FIRST_INDEX_MSB:0];
         if (i_reg_wdata[BIT_GO]) begin
            go_next = 1'b1;
         end
      end

      if (run_ok) begin
         case (state_reg)
            ST_IDLE: begin
               // [R3] start from first-step index
               // [R6] index used as given, reserved range is host's duty
               if (go_reg) begin
                  step_idx_next = first_idx_reg;
                  step_rd_next  = 1'b1;
                  busy_next     = 1'b1;
                  state_next    = ST_FETCH;
               end
            end
            ST_FETCH: begin
               // [R11] track accessed step
               progress_next = step_idx_reg;
               step_next     = i_step_word;
               state_next    = ST_EXEC;
            end
            ST_EXEC: begin
               ctl_wr_next   = 1'b1;
               ctl_next.addr = step_reg.addr;
               ctl_next.data = 16'({8'h00, step_reg.data & low_mask} << step_reg.start);
               ctl_next.mask = 16'({8'h00, low_mask} << step_reg.start);
               // [R16] total step time in units, less one
               wait_next     = 16'((17'h1 << step_reg.wait_code) + 17'(STEP_BASE_UNITS) - 17'h1);
               state_next    = ST_WAIT;
            end
            ST_WAIT: begin
               if (tick) begin
                  if (wait_reg != 16'h0000) begin
                     wait_next = wait_reg - 16'h0001;
                  // [R15] last flag ends sequence
                  end else if (step_reg.last) begin
                     // [R5] go clears itself
                     // A go written in the finishing cycle wins over the self-clear
                     go_next    = wr_run && i_reg_wdata[BIT_GO];
                     busy_next  = 1'b0;
                     // [R13] completion event
                     // [R14] raised with busy falling
                     done_next  = 1'b1;
                     state_next = ST_IDLE;
                  end else begin
                     // [R4] next consecutive step
                     step_idx_next = step_idx_reg + 6'h01;
                     step_rd_next  = 1'b1;
                     state_next    = ST_FETCH;
                  end
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end

      // [R7] cancel stops at once
      // [R19] clears running and go
      if (cancel) begin
         go_next      = 1'b0;
         busy_next    = 1'b0;
         done_next    = 1'b0;
         ctl_wr_next  = 1'b0;
         step_rd_next = 1'b0;
         state_next   = ST_IDLE;
      end

      if (i_reg_rd) begin
         case (i_reg_addr)
            ADDR_ENABLE_INDEX: begin
               rdata_next = 16'({clk_en_reg, 3'h0, wr_idx_reg});
            end
            ADDR_RUN_CONTROL: begin
               rdata_next = 16'({go_reg, 2'h0, first_idx_reg});
            end
            // [R8] running flag at bit 0
            // [R12] progress index held after finish
            ADDR_PROGRESS_STAT: begin
               rdata_next = 16'({progress_reg, 3'h0, busy_reg});
            end
            default: begin
               rdata_next = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg     <= ST_IDLE;
         clk_en_reg    <= RST_CLOCK_ENABLE;
         wr_idx_reg    <= RST_WRITE_INDEX;
         go_reg        <= RST_GO;
         first_idx_reg <= RST_FIRST_INDEX;
         progress_reg  <= RST_PROGRESS;
         busy_reg      <= 1'b0;
         step_idx_reg  <= 6'h00;
         step_reg      <= '0;
         wait_reg      <= 16'h0000;
         done_reg      <= 1'b0;
         ctl_wr_reg    <= 1'b0;
         ctl_reg       <= '0;
         step_rd_reg   <= 1'b0;
         rdata_reg     <= 16'h0000;
      end else begin
         state_reg     <= state_next;
         clk_en_reg    <= clk_en_next;
         wr_idx_reg    <= wr_idx_next;
         go_reg        <= go_next;
         first_idx_reg <= first_idx_next;
         progress_reg  <= progress_next;
         busy_reg      <= busy_next;
         step_idx_reg  <= step_idx_next;
         step_reg      <= step_next;
         wait_reg      <= wait_next;
         done_reg      <= done_next;
         ctl_wr_reg    <= ctl_wr_next;
         ctl_reg       <= ctl_next;
         step_rd_reg   <= step_rd_next;
         rdata_reg     <= rdata_next;
      end
   end

   // [R9] refuse other registers while running
   assign o_ctl_blocked       = busy_reg;
   assign o_reg_rdata         = rdata_reg;
   assign o_step_rd           = step_rd_reg;
   assign o_step_index        = step_idx_reg;
   assign o_ctl_wr            = ctl_wr_reg;
   assign o_ctl               = ctl_reg;
   assign o_seq_done_irq_flag = done_reg;
   assign o_seq_write_index   = wr_idx_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_disabled_stays_idle: assert property ( // [R1]
      !clk_en_reg && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
      else $error("sequencer left idle while disabled");

   a_go_starts_fetch: assert property ( // [R3]
      run_ok && state_reg == ST_IDLE && go_reg && !cancel
      |=> o_step_rd && o_step_index == $past(first_idx_reg) && busy_reg)
      else $error("go did not fetch first step");

   a_next_step_index: assert property ( // [R4]
      run_ok && state_reg == ST_WAIT && tick && wait_reg == 16'h0000 && !step_reg.last && !cancel
      |=> o_step_rd && o_step_index == $past(step_idx_reg) + 6'h01)
      else $error("next step not consecutive");

   a_go_self_clear: assert property ( // [R5]
      $rose(done_reg) |-> state_reg == ST_IDLE && (!go_reg || $past(wr_run && i_reg_wdata[BIT_GO])))
      else $error("go not cleared on finish");

   a_cancel_clears: assert property ( // [R7]
      cancel |=> !busy_reg && !go_reg && state_reg == ST_IDLE && !o_ctl_wr)
      else $error("cancel did not stop sequencer");

   a_busy_on_run: assert property ( // [R8]
      state_reg != ST_IDLE |-> busy_reg)
      else $error("running flag low during sequence");

   a_progress_hold: assert property ( // [R12]
      state_reg == ST_IDLE && !$past(state_reg == ST_FETCH) |=> $stable(progress_reg))
      else $error("progress index changed while idle");

   a_done_not_busy: assert property ( // [R14]
      done_reg |-> !busy_reg ##1 !done_reg)
      else $error("done flag with running flag");

   a_exec_writes: assert property ( // [R17]
      run_ok && state_reg == ST_EXEC && !cancel
      |=> o_ctl_wr && o_ctl.mask == 16'({8'h00, 8'hff >> (3'h7 - $past(step_reg.width))} << $past(step_reg.start)))
      else $error("control write mask wrong");

   a_step_length: assert property ( // [R16]
      run_ok && state_reg == ST_EXEC && !cancel
      |=> wait_reg == 16'((17'h1 << $past(step_reg.wait_code)) + 17'(STEP_BASE_UNITS) - 17'h1))
      else $error("step time load wrong");

   c_sequence_done:   cover property (done_reg);
   c_cancel_running:  cover property (busy_reg && cancel);
   c_multi_step:      cover property (state_reg == ST_WAIT ##1 state_reg == ST_FETCH);
endmodule // rws_seq_run_ctrl

/* tb/rws_step_mem.sv */
module rws_step_mem
   import rws_pkg::*;
(
   input  wire logic               i_clk,        // System clock
   input  wire logic               i_rst,        // Async reset, high
   input  wire logic               i_step_rd,    // Step read strobe
   input  wire logic [5:0]         i_step_index, // Step index
   output rws_pkg::rws_step_t      o_step_word   // Step word, valid in read cycle
);
   timeunit 1ns;
   timeprecision 1ps;
   import rws_pkg::*;

   rws_step_t word_reg;

   // -----------------------------
   // Step table: 8..15 one run, rest single steps
   // -----------------------------
   function automatic rws_step_t lookup(input logic [5:0] i);
      rws_step_t w;
      w.last      = !(i >= 6'h08 && i < 6'h0f);
      w.wait_code = (i == 6'h28) ? 4'h1 : 4'h0;
      w.width     = i[2:0];
      w.start     = {1'b0, i[2:0]};
      w.addr      = 8'h20 + {2'b00, i};
      w.data      = 8'hff;
      return w;
   endfunction

   // Sequencer latches the word in the read cycle itself; junk flips otherwise
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         word_reg <= 28'h5a5a5a5;
      end else begin
         word_reg <= ~word_reg;
      end
   end

   assign o_step_word = i_step_rd ? lookup(i_step_index) : word_reg;

endmodule // rws_step_mem

/* tb/tb_rws_seq_run_ctrl.sv */
module tb_rws_seq_run_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import rws_pkg::*;

   logic         i_clk, i_rst, i_system_clock_enable, i_reg_wr, i_reg_rd;
   logic [7:0]   i_reg_addr;
   logic [15:0]  i_reg_wdata, o_reg_rdata, rd_v, m;
   logic         o_ctl_blocked, o_step_rd, o_ctl_wr, o_seq_done_irq_flag;
   logic [5:0]   o_step_index;
   logic [4:0]   o_seq_write_index;
   rws_step_t    step_word;
   rws_ctl_wr_t  o_ctl;
   rws_ctl_wr_t  ctl_q[$];
   int           err_total, n_compared, done_cnt, steps_seen, gap, gap_on, k;

   rws_seq_run_ctrl #(.UNIT_CYC(4)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_system_clock_enable(i_system_clock_enable),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_ctl_blocked(o_ctl_blocked),
      .o_step_rd(o_step_rd), .o_step_index(o_step_index), .i_step_word(step_word),
      .o_ctl_wr(o_ctl_wr), .o_ctl(o_ctl), .o_seq_done_irq_flag(o_seq_done_irq_flag),
      .o_seq_write_index(o_seq_write_index));

   rws_step_mem mem (.i_clk(i_clk), .i_rst(i_rst), .i_step_rd(o_step_rd),
      .i_step_index(o_step_index), .o_step_word(step_word));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // -----------------------------
   // Tasks
   // -----------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      i_reg_wr = 1'b1; i_reg_addr = a; i_reg_wdata = d;
      @(posedge i_clk); #2;
      i_reg_wr = 1'b0;
   endtask

   // Data stands until the next read, so it is sampled a full cycle later
   task automatic reg_rd(input logic [7:0] a);
      i_reg_rd = 1'b1; i_reg_addr = a;
      @(posedge i_clk); #2;
      i_reg_rd = 1'b0;
      @(posedge i_clk); #2;
      rd_v = o_reg_rdata;
   endtask

   task automatic wait_done(input int bound);
      int d0;
      d0 = done_cnt;
      for (int j = 0; j < bound && done_cnt == d0; j++) begin
         @(posedge i_clk); #2;
      end
      if (done_cnt == d0) begin
         err_total++;
         $display("wrong value at %0t: sequence never finished", $time);
         tally_and_finish();
      end
   endtask

   // -----------------------------
   // Monitor
   // -----------------------------
   always @(posedge i_clk) begin
      gap++;
      if (o_ctl_wr) ctl_q.push_back(o_ctl);
      if (o_step_rd) begin
         steps_seen++;
         if (gap_on) chk(16'((gap >= 36 && gap <= 46) ? 1 : 0), 16'h0001, "step period");
         gap_on = 1;
         gap = 0;
      end
      if (o_seq_done_irq_flag) begin
         done_cnt++;
         gap_on = 0;
         chk({15'h0, o_ctl_blocked}, 16'h0000, "busy at done");
      end
   end

   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
      {err_total, n_compared, done_cnt, steps_seen, gap, gap_on} = '0;
      i_system_clock_enable = 1'b0;
      i_rst = 1'b1;
      repeat (2) @(posedge i_clk);
      #2;
      i_rst = 1'b0;
      i_system_clock_enable = 1'b1;
      reg_rd(ADDR_ENABLE_INDEX);  chk(rd_v, 16'h0000, "enable reset");
      reg_rd(ADDR_RUN_CONTROL);   chk(rd_v, 16'h0000, "run reset");
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v, 16'h0000, "status reset");
      reg_rd(8'h71);              chk(rd_v, 16'h0000, "unmapped");
      $display("test reset values done");

      // Go while sequencer clock off must not run
      reg_wr(ADDR_RUN_CONTROL, 16'h0108);
      repeat (20) @(posedge i_clk);
      #2;
      chk(16'(steps_seen), 16'h0000, "steps while off");
      reg_wr(ADDR_ENABLE_INDEX, 16'h0103);
      chk({11'h000, o_seq_write_index}, 16'h0003, "write index out");
      reg_rd(ADDR_ENABLE_INDEX);  chk(rd_v, 16'h0103, "enable readback");
      repeat (40) @(posedge i_clk);
      #2;
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v & 16'h0001, 16'h0001, "busy mid run");
      chk({15'h0000, o_ctl_blocked}, 16'h0001, "blocked mid run");
      reg_rd(ADDR_RUN_CONTROL);   chk(rd_v, 16'h0108, "go mid run");
      wait_done(1000);
      chk(16'(ctl_q.size()), 16'h0008, "step count");
      for (k = 0; k < 8; k++) begin
         m = ((16'h0001 << (k + 1)) - 16'h0001) << k;
         chk(ctl_q[k].data, m, "step data");
         chk(ctl_q[k].mask, m, "step mask");
         chk({8'h0, ctl_q[k].addr}, 16'(8'h28 + k), "step addr");
      end
      reg_rd(ADDR_RUN_CONTROL);   chk(rd_v, 16'h0008, "go cleared");
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v, 16'h00f0, "last index");
      $display("test ram sequence done");

      ctl_q.delete();
      reg_wr(ADDR_RUN_CONTROL, 16'h0128);
      wait_done(1000);
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v, 16'h0280, "rom index");
      chk(ctl_q[0].data, 16'h0001, "rom step data");
      $display("test rom sequence done");

      ctl_q.delete();
      reg_wr(ADDR_RUN_CONTROL, 16'h0108);
      for (k = 0; k < 200 && ctl_q.size() == 0; k++) @(posedge i_clk);
      #2;
      if (ctl_q.size() == 0) begin
         err_total++;
         $display("wrong value at %0t: first step never written", $time);
         tally_and_finish();
      end
      // Index field kept at 8, a bare cancel word would zero it
      reg_wr(ADDR_RUN_CONTROL, 16'h0208);
      gap_on = 0;
      k = done_cnt;
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v, 16'h0080, "cancel status");
      reg_rd(ADDR_RUN_CONTROL);   chk(rd_v, 16'h0008, "cancel go");
      repeat (100) @(posedge i_clk);
      #2;
      chk(16'(done_cnt - k), 16'h0000, "done after cancel");
      chk(16'(ctl_q.size()), 16'h0001, "writes after cancel");
      reg_wr(ADDR_RUN_CONTROL, 16'h0128);
      wait_done(1000);
      reg_rd(ADDR_PROGRESS_STAT); chk(rd_v, 16'h0280, "restart");
      $display("test cancel done");
      tally_and_finish();
   end

endmodule // tb_rws_seq_run_ctrl
